//--- core/flash_cmd_host.sv
// Purpose: Host controller issuing flash command sequences from software orders
// Assumes: Software writes address and data, then an operation code to REG_CMD
// Notes: Status polling of the device is left to software via OP_READ
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module flash_cmd_host
	import flash_host_pkg::*;
#(
	parameter int AW = 20,
	parameter int DW = 16,
	parameter int WINDOW_CYCLES = WINDOW_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic byteMode,
	output logic [AW-1:0] flashAddr,
	output logic [DW-1:0] flashDqOut,
	output logic flashDqOe,
	input wire logic [DW-1:0] flashDqIn,
	output logic flashCe_n,
	output logic flashWe_n,
	output logic flashOe_n,
	output logic flashByte_n,
	input wire logic ready_busy_output
);
	initial
	begin
		if (AW < 12 || DW < 8 || WINDOW_CYCLES < 2)
			$error("flash_cmd_host: unsupported parameters");
	end

	typedef enum logic [4:0] {H_IDLE = 5'b00001, H_ISSUE = 5'b00010, H_WAIT = 5'b00100,
		H_BUSY = 5'b01000, H_DONE = 5'b10000} host_t;
	host_t state;
	logic [AW-1:0] opAddr;
	logic [DW-1:0] opData;
	logic [3:0] op;
	logic [2:0] step;
	logic [2:0] nSteps;
	logic inAutosel, inBypass, refused, errFlag;
	logic [DW-1:0] readData;
	logic [31:0] windowCnt;
	logic [2:0] rbS;
	logic cycStart, cycDone;
	logic [DW-1:0] cycRdata;
	logic [AW-1:0] seqAddr;
	logic [DW-1:0] seqData;
	logic seqWrite;

	wire rbReady = rbS[1] & rbS[2];
	wire windowOpen = (windowCnt != 32'h0);

	////////////////////////////////////////////////////////////////
	// Sequence table: one combinational block serves address and data of each step
	function automatic logic [AW-1:0] unlockAddr(input logic second, input logic bm);
		logic [11:0] a;
		a = bm ? (second ? UNLOCK_ADDR2_BYTE : UNLOCK_ADDR1_BYTE)
			: (second ? UNLOCK_ADDR2_WORD : UNLOCK_ADDR1_WORD);
		unlockAddr = AW'(a);
	endfunction

	function automatic logic [2:0] stepsOf(input logic [3:0] o);
		case (o)
			OP_RESET, OP_READ, OP_SECTOR_ADD: stepsOf = 3'd1;
			OP_BYPASS_PROG, OP_BYPASS_EXIT: stepsOf = 3'd2;
			OP_AUTOSEL, OP_BYPASS_ENTER: stepsOf = 3'd3;
			OP_PROGRAM: stepsOf = 3'd4;
			default: stepsOf = 3'd6;
		endcase
	endfunction

	wire [7:0] cmdByte = (op == OP_AUTOSEL) ? CMD_AUTOSEL :
		(op == OP_BYPASS_ENTER) ? CMD_BYPASS :
		(op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
	wire [7:0] lastErase = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
	// Program ends on its fourth write, the erases on their sixth
	wire finalWrite = (op == OP_PROGRAM) ? (step == 3'd3) : (step == 3'd5);

	always_comb
	begin
		seqWrite = 1'b1;
		seqAddr = unlockAddr(1'b0, byteMode);
		seqData = DW'(CMD_UNLOCK1);
		case (op)
			OP_RESET:
				seqData = DW'(CMD_RESET);
			OP_READ:
			begin
				seqWrite = 1'b0;
				seqAddr = opAddr;
			end
			OP_SECTOR_ADD:
			begin
				seqAddr = opAddr;
				seqData = DW'(CMD_SECTOR_ERASE);
			end
			OP_BYPASS_PROG:
			begin
				seqData = (step == 3'd0) ? DW'(CMD_PROGRAM) : opData;
				seqAddr = (step == 3'd0) ? '0 : opAddr;
			end
			OP_BYPASS_EXIT:
			begin
				seqAddr = '0;
				seqData = (step == 3'd0) ? DW'(CMD_AUTOSEL) : DW'(CMD_BYP_EXIT2);
			end
			default:
				if (finalWrite)
				begin
					// Last write of program or sector erase carries the user address; chip erase uses the first unlock address
					seqAddr = (op == OP_CHIP_ERASE) ? unlockAddr(1'b0, byteMode) : opAddr;
					seqData = (op == OP_PROGRAM) ? opData : DW'(lastErase);
				end
				else
					case (step)
						3'd1, 3'd4:
						begin
							seqAddr = unlockAddr(1'b1, byteMode);
							seqData = DW'(CMD_UNLOCK2);
						end
						3'd2:
							seqData = DW'(cmdByte);
						default: ;
					endcase
		endcase
	end

	// Orders the device would refuse are refused here instead
	wire opLegal = (regWdata[3:0] == OP_RESET) || (regWdata[3:0] == OP_READ) ||
		(inBypass ? (regWdata[3:0] == OP_BYPASS_PROG || regWdata[3:0] == OP_BYPASS_EXIT)
		: (regWdata[3:0] == OP_SECTOR_ADD ? windowOpen
		: (regWdata[3:0] != OP_BYPASS_PROG && regWdata[3:0] != OP_BYPASS_EXIT && !inAutosel)));
	wire cmdWrite = regWr && regAddr == REG_CMD;
	wire accept = cmdWrite && state == H_IDLE && opLegal;
	wire lastStep = (step == nSteps - 3'd1);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		rbS <= {rbS[1:0], ready_busy_output};
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= H_IDLE;
			opAddr <= '0;
			opData <= '0;
			op <= OP_RESET;
			step <= 3'd0;
			nSteps <= 3'd1;
			inAutosel <= 1'b0;
			inBypass <= 1'b0;
			refused <= 1'b0;
			errFlag <= 1'b0;
			readData <= '0;
			windowCnt <= 32'h0;
		end
		else
		begin
			if (regWr && regAddr == REG_ADDR)
				opAddr <= AW'(regWdata);
			if (regWr && regAddr == REG_DATA)
				opData <= DW'(regWdata);
			if (windowOpen)
				windowCnt <= windowCnt - 32'h1;
			if (cmdWrite && !accept)
				refused <= 1'b1;
			else if (accept)
				refused <= 1'b0;
			case (state)
				H_IDLE:
					if (accept)
					begin
						op <= regWdata[3:0];
						nSteps <= stepsOf(regWdata[3:0]);
						step <= 3'd0;
						state <= H_ISSUE;
					end
				H_ISSUE:
					state <= H_WAIT;
				H_WAIT:
					if (cycDone)
					begin
						if (!seqWrite)
							readData <= cycRdata;
						if (!lastStep)
						begin
							step <= step + 3'd1;
							state <= H_ISSUE;
						end
						else
						begin
							case (op)
								OP_RESET:
								begin
									inAutosel <= 1'b0;
									windowCnt <= 32'h0;
								end
								OP_AUTOSEL: inAutosel <= 1'b1;
								OP_BYPASS_ENTER: inBypass <= 1'b1;
								OP_BYPASS_EXIT: inBypass <= 1'b0;
								OP_SECTOR_ERASE, OP_SECTOR_ADD: windowCnt <= 32'(WINDOW_CYCLES);
								default: ;
							endcase
							// Program and chip erase wait for the device to report ready; sector erases enter H_BUSY but return to idle while the window is open
							state <= (op == OP_PROGRAM || op == OP_BYPASS_PROG || op == OP_CHIP_ERASE ||
								op == OP_SECTOR_ERASE || op == OP_SECTOR_ADD) ? H_BUSY : H_DONE;
						end
					end
				H_BUSY:
					// Sector erase stays controllable while the window is open
					if ((op == OP_SECTOR_ERASE || op == OP_SECTOR_ADD) && windowOpen)
						state <= H_IDLE;
					else if (rbReady)
						state <= H_DONE;
				H_DONE:
				begin
					errFlag <= (op != OP_READ && op != OP_RESET) ? 1'b0 : errFlag;
					if (op == OP_READ && readData[DQ_EXCEED] && !inAutosel)
						errFlag <= 1'b1;
					state <= H_IDLE;
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	assign cycStart = (state == H_ISSUE);
	assign flashByte_n = ~byteMode;

	flash_bus_cycle #(.AW(AW), .DW(DW)) busCycle (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(cycStart),
		.isWrite(seqWrite),
		.addr(seqAddr),
		.wdata(seqData),
		.done(cycDone),
		.rdata(cycRdata),
		.flashAddr(flashAddr),
		.flashDqOut(flashDqOut),
		.flashDqOe(flashDqOe),
		.flashDqIn(flashDqIn),
		.flashCe_n(flashCe_n),
		.flashWe_n(flashWe_n),
		.flashOe_n(flashOe_n)
	);

	////////////////////////////////////////////////////////////////
	wire [31:0] statusWord = 32'({refused, windowOpen, errFlag, inBypass, inAutosel, rbReady, state != H_IDLE});
	wire [31:0] readMux = (regAddr == REG_STATUS) ? statusWord :
		(regAddr == REG_RDATA) ? 32'(readData) :
		(regAddr == REG_ADDR) ? 32'(opAddr) :
		(regAddr == REG_DATA) ? 32'(opData) : 32'h0;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			regRdata <= 32'h0;
		else if (regRd)
			regRdata <= readMux;
	end
endmodule

//--- core/flash_host_pkg.sv
// Purpose: Shared constants for the parallel NOR flash command controller
// Assumes: Word mode bus addressing unless byteMode is set
// Notes: Command data values and unlock addresses used by the host and the device model
package flash_host_pkg;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [11:0] UNLOCK_ADDR1_WORD = 12'h555;
	localparam logic [11:0] UNLOCK_ADDR2_WORD = 12'h2aa;
	localparam logic [11:0] UNLOCK_ADDR1_BYTE = 12'haaa;
	localparam logic [11:0] UNLOCK_ADDR2_BYTE = 12'h555;
	// Autoselect low address offsets
	localparam logic [7:0] AS_MANUF = 8'h00;
	localparam logic [7:0] AS_DEVICE = 8'h01;
	localparam logic [7:0] AS_PROTECT = 8'h02;
	localparam logic [7:0] AS_CONTIN = 8'h11;
	// Host operation codes
	localparam logic [3:0] OP_RESET = 4'h0;
	localparam logic [3:0] OP_AUTOSEL = 4'h1;
	localparam logic [3:0] OP_PROGRAM = 4'h2;
	localparam logic [3:0] OP_BYPASS_ENTER = 4'h3;
	localparam logic [3:0] OP_BYPASS_PROG = 4'h4;
	localparam logic [3:0] OP_BYPASS_EXIT = 4'h5;
	localparam logic [3:0] OP_CHIP_ERASE = 4'h6;
	localparam logic [3:0] OP_SECTOR_ERASE = 4'h7;
	localparam logic [3:0] OP_SECTOR_ADD = 4'h8;
	localparam logic [3:0] OP_READ = 4'h9;
	// Register map of the controller
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_AUTOSEL = 2;
	localparam int ST_BYPASS = 3;
	localparam int ST_ERROR = 4;
	localparam int ST_WINDOW = 5;
	localparam int ST_REFUSED = 6;
	// Bus timing: one bus phase in ns and the window in us
	localparam int PHASE_NS = 40;
	localparam int CLK_NS = 10;
	localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WINDOW_US = 50;
	localparam int WINDOW_CYC = WINDOW_US * 1000 / CLK_NS;
	// Status bit positions on the device data bus
	localparam int DQ_POLL = 7;
	localparam int DQ_TOGGLE = 6;
	localparam int DQ_EXCEED = 5;
	localparam int DQ_TIMER = 3;
	localparam int DQ_SECTOR_TOGGLE = 2;
endpackage

//--- core/flash_bus_cycle.sv
// Purpose: One write or read cycle on the flash parallel pins
// Assumes: Chip enable held low through the cycle, write enable strobes a write and output enable a read
// Notes: Address is set before the write enable falls, data holds past its rise
`timescale 1ns/1ps
module flash_bus_cycle
	import flash_host_pkg::*;
#(
	parameter int AW = 20,
	parameter int DW = 16
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic isWrite,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic done,
	output logic [DW-1:0] rdata,
	output logic [AW-1:0] flashAddr,
	output logic [DW-1:0] flashDqOut,
	output logic flashDqOe,
	input wire logic [DW-1:0] flashDqIn,
	output logic flashCe_n,
	output logic flashWe_n,
	output logic flashOe_n
);
	typedef enum logic [3:0] {IDLE = 4'b0001, SETUP = 4'b0010, STROBE = 4'b0100, HOLD = 4'b1000} cyc_t;
	cyc_t state;
	logic [7:0] cnt;
	logic writeCyc;
	logic [DW-1:0] dqS1, dqS2, dqS3;
	wire phaseDone = (cnt == 8'(PHASE_CYC - 1));

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		dqS1 <= flashDqIn;
		dqS2 <= dqS1;
		dqS3 <= dqS2;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= IDLE;
			cnt <= 8'h00;
			writeCyc <= 1'b0;
			done <= 1'b0;
			rdata <= '0;
			flashAddr <= '0;
			flashDqOut <= '0;
			flashDqOe <= 1'b0;
			flashCe_n <= 1'b1;
			flashWe_n <= 1'b1;
			flashOe_n <= 1'b1;
		end
		else
		begin
			done <= 1'b0;
			cnt <= phaseDone ? 8'h00 : cnt + 8'h01;
			case (state)
				IDLE:
				begin
					cnt <= 8'h00;
					if (start)
					begin
						state <= SETUP;
						writeCyc <= isWrite;
						flashAddr <= addr;
						flashDqOut <= wdata;
						flashDqOe <= isWrite;
						flashCe_n <= 1'b0;
					end
				end
				SETUP:
					if (phaseDone)
					begin
						state <= STROBE;
						flashWe_n <= ~writeCyc;
						flashOe_n <= writeCyc;
					end
				STROBE:
					if (phaseDone)
					begin
						// Read data taken while output enable is still low; the bus floats once it rises
						if (!writeCyc && dqS2 == dqS3)
							rdata <= dqS3;
						// Data latched by device on this rise, so keep it driven one more phase
						state <= HOLD;
						flashWe_n <= 1'b1;
						flashOe_n <= 1'b1;
					end
				HOLD:
					if (phaseDone)
					begin
						state <= IDLE;
						flashDqOe <= 1'b0;
						flashCe_n <= 1'b1;
						done <= 1'b1;
					end
				default: state <= IDLE;
			endcase
		end
	end
endmodule

//--- bench/flash_cmd_host_chk.sv
// Purpose: Pin and reset relations of the flash command host
// Assumes: One clock, synchronous active-high reset
// Notes: Setup, strobe and hold phases are four clocks each
`timescale 1ns/1ps
module flash_cmd_host_chk
#(
	parameter int AW = 20,
	parameter int DW = 16
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic byteMode,
	input wire logic [31:0] regRdata,
	input wire logic [AW-1:0] flashAddr,
	input wire logic [DW-1:0] flashDqOut,
	input wire logic flashDqOe,
	input wire logic flashCe_n,
	input wire logic flashWe_n,
	input wire logic flashOe_n,
	input wire logic flashByte_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	//////////////////////////////
	a_we_under_ce: assert property (!flashWe_n |-> !flashCe_n && flashOe_n && flashDqOe)
		else $error("write strobe outside a driven write");
	a_addr_hold: assert property (!flashWe_n && $past(!flashWe_n) |-> $stable(flashAddr))
		else $error("address moved under write strobe");
	a_data_hold: assert property ($rose(flashWe_n) |-> flashDqOe && $stable(flashDqOut))
		else $error("data moved at write strobe release");
	a_we_width: assert property ($fell(flashWe_n) |-> !flashWe_n [*4] ##1 flashWe_n)
		else $error("write strobe width wrong");
	a_ce_lead: assert property ($fell(flashWe_n) |-> !$past(flashCe_n, 4))
		else $error("chip enable not leading write strobe");
	a_ce_trail: assert property ($rose(flashWe_n) |-> !flashCe_n [*4] ##1 flashCe_n)
		else $error("chip enable release wrong");
	a_read_quiet: assert property (!flashOe_n |-> !flashDqOe && flashWe_n && !flashCe_n)
		else $error("bus clash during read");
	a_byte_pin: assert property (flashByte_n != byteMode)
		else $error("width select pin wrong");
	a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> flashCe_n && flashWe_n && !flashDqOe && regRdata == '0)
		else $error("pins not idle after reset");
	c_write: cover property ($fell(flashWe_n));
	c_read: cover property ($fell(flashOe_n));
	c_byte_write: cover property (byteMode && $fell(flashWe_n));
endmodule
bind flash_cmd_host flash_cmd_host_chk #(.AW(AW), .DW(DW)) u_chk (.clk(clk), .sys_rst(sys_rst), .byteMode(byteMode),
	.regRdata(regRdata), .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCe_n(flashCe_n),
	.flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashByte_n(flashByte_n));

//--- bench/flash_dev_model.sv
// Purpose: Behavioural parallel NOR flash facing the command host
// Assumes: Chip enable falls before and rises after write enable
// Notes: Busy time and sector window are short; identity codes are arbitrary
`timescale 1ns/1ps
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter int AW = 20,
	parameter int DW = 16,
	parameter logic [15:0] ID_M = 16'h00a1,
	parameter logic [15:0] ID_D = 16'h00b2,
	parameter logic [15:0] ID_C = 16'h00c3,
	parameter int BUSY = 40,
	parameter int WIN = 200
)
(
	input wire logic clk,
	input wire logic [AW-1:0] flashAddr,
	input wire logic [DW-1:0] flashDqOut,
	input wire logic flashDqOe,
	input wire logic flashCe_n,
	input wire logic flashWe_n,
	input wire logic flashOe_n,
	input wire logic flashByte_n,
	output logic [DW-1:0] flashDqIn,
	output logic ready_busy_output
);
	logic [DW-1:0] mem [logic [AW-1:0]];
	logic [AW-1:0] wa [$];
	logic [DW-1:0] wd [$];
	logic [AW-1:0] latA, u1, u2;
	logic [DW-1:0] q = '0;
	int step = 0, busyCnt = 0, winCnt = 0, sectors = 0, badSeq = 0;
	bit autoSel = 0, bypass = 0, progNext = 0, exitNext = 0;
	assign u1 = flashByte_n ? AW'(UNLOCK_ADDR1_WORD) : AW'(UNLOCK_ADDR1_BYTE);
	assign u2 = flashByte_n ? AW'(UNLOCK_ADDR2_WORD) : AW'(UNLOCK_ADDR2_BYTE);
	// Undriven bus moves every half cycle so stale data never looks valid
	assign flashDqIn = flashDqOe ? flashDqOut : (!flashCe_n && !flashOe_n) ? q : {DW{clk}} ^ DW'(16'h5a5a);
	assign ready_busy_output = busyCnt == 0 && winCnt == 0;
	//////////////////////////////
	function automatic logic [DW-1:0] readVal(input logic [AW-1:0] a);
		if (!autoSel)
			return mem.exists(a) ? mem[a] : '1;
		case (a[7:0])
			AS_MANUF: return ID_M;
			AS_DEVICE: return ID_D;
			AS_CONTIN: return ID_C;
			AS_PROTECT: return DW'(a[AW-1:12] == 3);
			default: return '0;
		endcase
	endfunction
	always @(posedge clk) q <= readVal(flashAddr);
	always @(negedge flashWe_n) latA = flashAddr;
	always @(posedge flashWe_n) if (!flashCe_n) take(latA, flashDqIn);
	//////////////////////////////
	task automatic take(input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [7:0] c;
		bit ok;
		c = d[7:0];
		wa.push_back(a);
		wd.push_back(d);
		if (busyCnt > 0)
			return;
		if (winCnt > 0)
		begin
			winCnt = c == CMD_SECTOR_ERASE ? WIN : 0;
			sectors = winCnt > 0 ? sectors + 1 : 0;
		end
		else if (progNext)
		begin
			mem[a] = (mem.exists(a) ? mem[a] : '1) & d;
			progNext = 0;
			busyCnt = BUSY;
		end
		else if (bypass)
		begin
			if (exitNext)
				bypass = c != CMD_BYP_EXIT2;
			progNext = c == CMD_PROGRAM;
			exitNext = !exitNext && c == CMD_AUTOSEL;
		end
		else if (c == CMD_RESET)
		begin
			autoSel = 0;
			step = 0;
		end
		else
		begin
			case (step)
				0, 3: ok = c == CMD_UNLOCK1 && a == u1;
				1, 4: ok = c == CMD_UNLOCK2 && a == u2;
				2: ok = c inside {CMD_AUTOSEL, CMD_PROGRAM, CMD_BYPASS, CMD_ERASE_SETUP};
				default: ok = c inside {CMD_CHIP_ERASE, CMD_SECTOR_ERASE};
			endcase
			badSeq += ok ? 0 : 1;
			step = ok ? step + 1 : 0;
			if (step == 3 && c != CMD_ERASE_SETUP)
			begin
				autoSel = c == CMD_AUTOSEL;
				bypass = c == CMD_BYPASS;
				progNext = c == CMD_PROGRAM;
				step = 0;
			end
			if (step == 6)
			begin
				if (c == CMD_CHIP_ERASE)
					mem.delete();
				busyCnt = c == CMD_CHIP_ERASE ? BUSY : 0;
				winCnt = c == CMD_SECTOR_ERASE ? WIN : 0;
				sectors = 1;
				step = 0;
			end
		end
	endtask
	always @(posedge clk)
	begin
		if (busyCnt > 0)
			busyCnt--;
		if (winCnt == 1)
			busyCnt = BUSY;
		if (winCnt > 0)
			winCnt--;
	end
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the flash command host
// Assumes: Register strobes follow the plain one-cycle port protocol
// Notes: Window shortened to 50 clocks; device busy time is 40 clocks
`timescale 1ns/1ps
module testbench
	import flash_host_pkg::*;
;
	localparam logic [15:0] ID_M = 16'h00a1;  // Arbitrary identity values
	localparam logic [15:0] ID_D = 16'h00b2;
	localparam logic [15:0] ID_C = 16'h00c3;
	typedef struct {logic [3:0] code; logic [19:0] a; logic [15:0] d; int nw; logic [15:0] exp; logic refused;} row_t;
	logic clk = 0;
	logic sys_rst = 1;
	logic regWr = 0;
	logic regRd = 0;
	logic byteMode = 0;
	logic [3:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic [31:0] regRdata, s, v;
	logic [19:0] flashAddr;
	logic [15:0] flashDqOut, flashDqIn;
	logic flashDqOe, flashCe_n, flashWe_n, flashOe_n, flashByte_n, ready_busy_output;
	int fails = 0;
	int comparisons = 0;
	int n0;
	row_t rows [$] = '{'{OP_PROGRAM, 20'h00100, 16'h1234, 4, 16'h1234, 0}, '{OP_READ, 20'h00100, 0, 0, 16'h1234, 0},
		'{OP_AUTOSEL, 0, 0, 3, 16'h0090, 0}, '{OP_READ, 20'h00000, 0, 0, ID_M, 0}, '{OP_READ, 20'h00001, 0, 0, ID_D, 0},
		'{OP_READ, 20'h00011, 0, 0, ID_C, 0}, '{OP_READ, 20'h03002, 0, 0, 16'h0001, 0},
		'{OP_READ, 20'h04002, 0, 0, 16'h0000, 0}, '{OP_PROGRAM, 20'h00300, 0, 0, 0, 1}, '{OP_RESET, 0, 0, 1, 16'h00f0, 0},
		'{OP_READ, 20'h00000, 0, 0, 16'hffff, 0}, '{OP_SECTOR_ADD, 20'h06000, 0, 0, 0, 1},
		'{OP_BYPASS_ENTER, 0, 0, 3, 16'h0020, 0}, '{OP_PROGRAM, 20'h00300, 0, 0, 0, 1},
		'{OP_BYPASS_PROG, 20'h00200, 16'h00f0, 2, 16'h00f0, 0}, '{OP_BYPASS_PROG, 20'h00201, 16'haaaa, 2, 16'haaaa, 0},
		'{OP_BYPASS_EXIT, 0, 0, 2, 16'h0000, 0}, '{OP_READ, 20'h00200, 0, 0, 16'h00f0, 0},
		'{OP_PROGRAM, 20'h00200, 16'hff0f, 4, 16'hff0f, 0}, '{OP_READ, 20'h00200, 0, 0, 16'h0000, 0},
		'{OP_CHIP_ERASE, 0, 0, 6, 16'h0010, 0}, '{OP_READ, 20'h00201, 0, 0, 16'hffff, 0},
		'{OP_SECTOR_ERASE, 20'h05000, 0, 6, 16'h0030, 0}, '{OP_SECTOR_ADD, 20'h06000, 0, 1, 16'h0030, 0}};
	always #5 clk = ~clk;
	flash_cmd_host #(.AW(20), .DW(16), .WINDOW_CYCLES(50)) u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .byteMode(byteMode),
		.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
		.flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashByte_n(flashByte_n),
		.ready_busy_output(ready_busy_output));
	flash_dev_model #(.ID_M(ID_M), .ID_D(ID_D), .ID_C(ID_C), .WIN(50)) u_dev (.clk(clk), .flashAddr(flashAddr),
		.flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCe_n(flashCe_n), .flashWe_n(flashWe_n),
		.flashOe_n(flashOe_n), .flashByte_n(flashByte_n), .flashDqIn(flashDqIn), .ready_busy_output(ready_busy_output));
	//////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1;
		@(posedge clk);
		regWr <= 0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		regAddr <= a;
		regRd <= 1;
		@(posedge clk);
		regRd <= 0;
		#1 d = regRdata;
		@(posedge clk);
	endtask
	task automatic op(input logic [3:0] code, input logic [19:0] a, input logic [15:0] d, output logic [31:0] st);
		int k;
		wr(REG_ADDR, 32'(a));
		wr(REG_DATA, 32'(d));
		wr(REG_CMD, 32'(code));
		for (k = 0; k < 3000; k++)
		begin
			rd(REG_STATUS, st);
			if (st[ST_BUSY] === 1'b0)
				break;
		end
		check(32'(k < 3000), 1, "busy cleared");
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	//////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		rd(REG_RDATA, v);
		check(v, 0, "read data after reset");
		foreach (rows[i])
		begin
			n0 = u_dev.wa.size();
			op(rows[i].code, rows[i].a, rows[i].d, s);
			check(s[ST_REFUSED], rows[i].refused, "refused flag");
			check(u_dev.wa.size() - n0, rows[i].nw, "write count");
			if (rows[i].nw > 0) check(u_dev.wd[$], rows[i].exp, "last data");
			if (rows[i].code inside {OP_PROGRAM, OP_BYPASS_PROG, OP_SECTOR_ERASE, OP_SECTOR_ADD} && rows[i].nw > 0)
				check(u_dev.wa[$], rows[i].a, "last address");
			if (rows[i].code == OP_READ) rd(REG_RDATA, v);
			if (rows[i].code == OP_READ) check(v, rows[i].exp, "read data");
		end
		check(u_dev.sectors, 2, "sectors queued");
		// Design window is fixed at 50 clocks here
		repeat (60) @(posedge clk);
		rd(REG_STATUS, s);
		check(s[ST_WINDOW], 0, "window closed");
		// The device now erases and ignores orders, so wait for it to report ready
		for (n0 = 0; n0 < 300; n0++)
		begin
			rd(REG_STATUS, s);
			if (s[ST_READY] === 1'b1)
				break;
		end
		check(32'(n0 < 300), 1, "ready after sector erase");
		byteMode <= 1;
		n0 = u_dev.wa.size();
		op(OP_AUTOSEL, '0, '0, s);
		check(s[ST_AUTOSEL], 1, "autoselect flag");
		check(u_dev.wa[n0], 20'haaa, "byte unlock");
		check(u_dev.wa[n0 + 1], 20'h555, "byte unlock");
		op(OP_RESET, '0, '0, s);
		check(s[ST_AUTOSEL], 0, "autoselect flag");
		check(u_dev.badSeq, 0, "sequence errors");
		wr(REG_CMD, 32'(OP_PROGRAM));
		repeat (6) @(posedge clk);
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		rd(REG_STATUS, s);
		check(s[ST_BUSY], 0, "busy after reset");
		print_verdict();
	end
	initial
	begin
		#200000;
		$display("FAIL %0t watchdog expired", $time);
		fails++;
		print_verdict();
	end
endmodule
